// File: dv/bridge_driver_model.sv
// Switch drivers on bridge legs A/B and C/D.
// Assumes active-high inputs; counts shorted-leg cycles.
`timescale 1ns/1ps
`default_nettype none
module bridge_driver_model (
    input  wire logic       clk,
    input  wire logic [3:0] pins,
    input  wire logic [3:0] en,
    output int              overlap_cnt
);
    logic [3:0] on;
    // ==========================================================
    // undriven pin leaves switch off
    assign on = pins & en;
    initial overlap_cnt = 0;
    always @(posedge clk) begin
        if ((on[0] && on[1]) || (on[2] && on[3])) begin
            overlap_cnt <= overlap_cnt + 1;
        end
    end
endmodule : bridge_driver_model
`default_nettype wire

// File: dv/pwm_generator_sva.sv
// Port-level checks for the PWM generator.
// Assumes hready is the generator's own hreadyout.
`timescale 1ns/1ps
`default_nettype none
module pwm_generator_sva
    import pwm_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        main_pwm_pin,
    input wire logic        bridge_out_b,
    input wire logic        bridge_out_c,
    input wire logic        bridge_out_d,
    input wire logic [3:0]  pin_drive
);
    // ==========================================================
    // Shadow of the control byte
    localparam logic [7:0] UNMAPPED_IDX = 8'h40;
    logic        ap_q;
    logic        wr_q;
    logic [31:0] ad_q;
    logic [7:0]  ctrl_q;
    logic [7:0]  st_q;
    logic        setl;
    logic [1:0]  cfg;
    logic [1:0]  pol;
    // Long enough for new controls to load
    assign setl = st_q == 8'hFF && ctrl_q[3:2] == MODE_PWM_HI;
    assign cfg  = ctrl_q[7:6];
    assign pol  = ctrl_q[1:0];
    always_ff @(posedge clk) begin
        if (hready) begin
            ap_q <= rst_n && hsel && htrans[1];
            wr_q <= hwrite;
            ad_q <= haddr;
        end
        if (!rst_n) begin
            ctrl_q <= 8'h00;
            st_q   <= 8'h00;
        end else if (hready && ap_q && wr_q && ad_q[9:2] == IDX_MODULE_CTRL) begin
            ctrl_q <= hwdata[7:0];
            st_q   <= 8'h00;
        end else if (st_q != 8'hFF) begin
            st_q <= st_q + 8'h01;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
        else $error("no read wait");
    a_write_nowait: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout && !hresp)
        else $error("write stalled");
    a_hrdata_byte: assert property (ap_q && !wr_q && hready |-> hrdata[31:8] == 24'h0)
        else $error("hrdata high bits");
    a_read_unmapped: assert property (ap_q && !wr_q && hready && ad_q[9:2] == UNMAPPED_IDX |-> hrdata == 32'h0)
        else $error("unmapped read data");
    a_off_low: assert property ((ctrl_q == 8'h00) [*8] |-> !main_pwm_pin && pin_drive == 4'h0)
        else $error("outputs on while off");
    a_drive_map: assert property (setl |-> pin_drive == (cfg == CFG_SINGLE ? 4'h1 : cfg == CFG_HALF ? 4'h3 : 4'hF))
        else $error("pin drive wrong");
    a_fwd_levels: assert property (setl && cfg == CFG_FWD |-> main_pwm_pin == !pol[1] && bridge_out_b == pol[0] && bridge_out_c == pol[1])
        else $error("forward levels");
    a_rev_levels: assert property (setl && cfg == CFG_REV |-> bridge_out_c == !pol[1] && main_pwm_pin == pol[1] && bridge_out_d == pol[0])
        else $error("reverse levels");
    a_half_gap: assert property (setl && cfg == CFG_HALF && pol == 2'h0 |-> !(main_pwm_pin && bridge_out_b))
        else $error("legs overlap");
endmodule : pwm_generator_sva
bind pwm_generator pwm_generator_sva i_sva (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .main_pwm_pin, .bridge_out_b, .bridge_out_c, .bridge_out_d, .pin_drive);
`default_nettype wire

// File: dv/tb_enhanced_pwm_generator.sv
// Self-checking bench for the PWM generator.
// Assumes the bound checker and a driver model on the pins.
`timescale 1ns/1ps
`default_nettype none
module tb_enhanced_pwm_generator
    import pwm_pkg::*;
;
    typedef struct {logic [7:0] idx; logic wr; logic [7:0] wd; logic [7:0] rd;} reg_s;
    typedef struct {logic [7:0] p; logic [9:0] d; logic [1:0] pre; logic [1:0] cfg; logic [3:0] mode;
                    int pin; int kind;} row_s;
    localparam logic [7:0] UNMAPPED_IDX = 8'h40;
    logic            clk;
    logic            rst_n;
    logic [31:0]     haddr;
    logic [1:0]      htrans;
    logic            hwrite;
    logic [31:0]     hwdata;
    logic            hreadyout;
    logic            hresp;
    logic [31:0]     hrdata;
    wire logic [3:0] pins;
    wire logic [3:0] pin_drive;
    int              error_cnt;
    int              total_checks;
    int              overlap_cnt;
    reg_s regs [15] = '{'{IDX_IRQ_FLAGS, 1'b0, 8'h00, 8'h00}, '{IDX_TIMER_COUNT, 1'b0, 8'h00, 8'h00},
        '{IDX_TIMER_CTRL, 1'b0, 8'h00, 8'h00}, '{IDX_MODULE_CTRL, 1'b0, 8'h00, 8'h00},
        '{IDX_IRQ_EN, 1'b0, 8'h00, 8'h00}, '{IDX_PERIOD_LIMIT, 1'b0, 8'h00, 8'hFF},
        '{IDX_IRQ_EN, 1'b1, 8'hFF, 8'h47}, '{IDX_IRQ_FLAGS, 1'b1, 8'hFF, 8'h47},
        '{IDX_IRQ_FLAGS, 1'b1, 8'h00, 8'h00}, '{IDX_DUTY_BUF, 1'b1, 8'hAA, 8'h00},
        '{UNMAPPED_IDX, 1'b1, 8'hFF, 8'h00}, '{IDX_TIMER_CTRL, 1'b1, 8'h80, 8'h00},
        '{IDX_TIMER_COUNT, 1'b1, 8'h07, 8'h07}, '{IDX_MODULE_CTRL, 1'b1, 8'h30, 8'h30},
        '{IDX_DEADBAND, 1'b1, 8'h05, 8'h05}};
    // Kind: 0 mod, 1 active, 2 inactive, 3 inverse
    row_s rows [14] = '{'{8'h09, 10'h00D, 2'h0, CFG_SINGLE, 4'hC, 0, 0}, '{8'h03, 10'h005, 2'h1, CFG_SINGLE, 4'hC, 0, 0},
        '{8'h01, 10'h003, 2'h2, CFG_SINGLE, 4'hC, 0, 0}, '{8'h03, 10'h000, 2'h0, CFG_SINGLE, 4'hC, 0, 0},
        '{8'h03, 10'h028, 2'h0, CFG_SINGLE, 4'hC, 0, 0}, '{8'h09, 10'h00D, 2'h0, CFG_SINGLE, 4'hE, 0, 0},
        '{8'h09, 10'h00D, 2'h0, CFG_FWD, 4'hC, 0, 1}, '{8'h09, 10'h00D, 2'h0, CFG_FWD, 4'hC, 3, 0},
        '{8'h09, 10'h00D, 2'h0, CFG_FWD, 4'hC, 1, 2}, '{8'h09, 10'h00D, 2'h0, CFG_REV, 4'hC, 2, 1},
        '{8'h09, 10'h00D, 2'h0, CFG_REV, 4'hC, 1, 0}, '{8'h09, 10'h00C, 2'h0, CFG_HALF, 4'hC, 0, 0},
        '{8'h09, 10'h00C, 2'h0, CFG_HALF, 4'hC, 1, 3}, '{8'h09, 10'h00D, 2'h0, CFG_FWD, 4'hD, 3, 0}};
    pwm_generator i_dut (.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .main_pwm_pin(pins[0]), .bridge_out_b(pins[1]),
        .bridge_out_c(pins[2]), .bridge_out_d(pins[3]), .pin_drive);
    bridge_driver_model i_drv (.clk, .pins, .en(pin_drive), .overlap_cnt);
    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata[7:0];
    endtask : bus
    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // ==========================================================
    // Stimulus
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        logic [7:0] rd;
        logic       prev;
        int         pre, per, db, hi, ed, eh;
        row_s       w;
        rst_n = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        error_cnt = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        foreach (regs[i]) begin
            if (regs[i].wr) bus(regs[i].idx, 1'b1, regs[i].wd, rd);
            bus(regs[i].idx, 1'b0, 8'h00, rd);
            chk({24'h0, rd}, {24'h0, regs[i].rd});
        end
        foreach (rows[i]) begin
            w = rows[i];
            pre = w.pre == PRE_DIV1 ? 1 : w.pre == PRE_DIV4 ? 4 : 16;
            per = 4 * (w.p + 1) * pre;
            db = w.cfg == CFG_HALF ? 1 : 0;
            if (i == 13) chk(overlap_cnt, 0);
            bus(IDX_PERIOD_LIMIT, 1'b1, w.p, rd);
            bus(IDX_DUTY_WRITE, 1'b1, w.d[9:2], rd);
            bus(IDX_DEADBAND, 1'b1, 8'(db), rd);
            bus(IDX_TIMER_CTRL, 1'b1, {1'b0, w.pre, w.pre, 1'b1, w.pre}, rd);
            bus(IDX_TIMER_COUNT, 1'b1, 8'h00, rd);
            bus(IDX_MODULE_CTRL, 1'b1, {w.cfg, w.d[1:0], w.mode}, rd);
            repeat (3 * per + 100) @(posedge clk);
            hi = 0;
            ed = 0;
            prev = pins[w.pin];
            // Whole periods hold a fixed high time
            repeat (2 * per) begin
                @(posedge clk);
                hi += int'(pins[w.pin] === 1'b1);
                ed += int'(pins[w.pin] === 1'b1 && prev === 1'b0);
                prev = pins[w.pin];
            end
            eh = w.d * pre;
            if (eh > per) eh = per;
            case (w.kind)
                1: eh = per;
                2: eh = 0;
                3: eh = per - eh - 4 * db;
                default: eh = eh - 4 * db;
            endcase
            if ((w.pin % 2 == 1) ? w.mode[0] : w.mode[1]) eh = per - eh;
            chk(hi, 2 * eh);
            chk(ed, (eh > 0 && eh < per) ? 2 : 0);
            chk(pin_drive, w.cfg == CFG_SINGLE ? 4'h1 : w.cfg == CFG_HALF ? 4'h3 : 4'hF);
        end
        bus(IDX_IRQ_FLAGS, 1'b0, 8'h00, rd);
        chk({24'h0, rd & 8'h02}, 32'h2);
        bus(IDX_MODULE_CTRL, 1'b1, 8'h00, rd);
        repeat (8) @(posedge clk);
        chk({pin_drive, pins}, 32'h0);
        bus(IDX_MODULE_CTRL, 1'b1, 8'h0C, rd);
        repeat (100) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({pin_drive, pins}, 32'h0);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        bus(IDX_PERIOD_LIMIT, 1'b0, 8'h00, rd);
        chk({24'h0, rd}, 32'hFF);
        end_of_test();
    end
endmodule : tb_enhanced_pwm_generator
`default_nettype wire

// File: logic/pwm_deadband.sv
// Delays the rising (inactive to active) edge of one bridge leg.
// Falling edges pass at once so the leg never overlaps its partner.
`timescale 1ns/1ps
`default_nettype none
module pwm_deadband (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       mod_in,
    input  wire logic [6:0] delay,
    output logic            mod_out
);

    logic [8:0] cnt_q;
    logic [8:0] cnt_d;
    logic       out_q;
    logic       out_d;

    // ============================================================
    // Turn-on delay counter
    always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (!mod_in) begin
            cnt_d = {delay, 2'h0};
            out_d = 1'b0;
        end else if (cnt_q == 9'h000) begin
            out_d = 1'b1;
        end else begin
            cnt_d = cnt_q - 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 9'h000;
            out_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign mod_out = out_q;

endmodule : pwm_deadband
`default_nettype wire

// File: logic/pwm_generator.sv
// Enhanced PWM generator: period timer, double-buffered duty compare,
// four-pin output stage with polarity, dead band, AHB-Lite registers.
// Assumes a single AHB-Lite master and one 100 MHz clock domain.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module pwm_generator
    import pwm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             main_pwm_pin,
    output logic             bridge_out_b,
    output logic             bridge_out_c,
    output logic             bridge_out_d,
    output logic [3:0]       pin_drive
);

    // ============================================================
    // Register state
    logic [7:0]  irq_flags_q, irq_flags_d;
    logic [7:0]  timer_count_q, timer_count_d;
    logic [7:0]  timer_ctrl_q, timer_ctrl_d;
    logic [7:0]  duty_write_q, duty_write_d;
    logic [7:0]  duty_buf_q, duty_buf_d;
    logic [1:0]  duty_lat_q, duty_lat_d;
    logic [7:0]  module_ctrl_q, module_ctrl_d;
    logic [7:0]  irq_en_q, irq_en_d;
    logic [7:0]  period_limit_q, period_limit_d;
    logic [7:0]  deadband_q, deadband_d;
    logic [3:0]  post_cnt_q, post_cnt_d;

    // Bus state
    logic        wr_pend_q, wr_pend_d;
    logic        rd_wait_q, rd_wait_d;
    logic [7:0]  idx_q, idx_d;
    logic        hit_q, hit_d;
    logic [31:0] hrdata_q, hrdata_d;

    // Waveform state
    logic [1:0]  phase_q, phase_d;
    logic        start_q, start_d;
    logic        std_q, std_d;
    logic [ENH_LAG-1:0] lag_q, lag_d;
    logic [3:0]  cfg_q, cfg_d;
    logic        enh_on_q, enh_on_d;
    logic [6:0]  db_q, db_d;
    logic [3:0]  pins_q, pins_d;
    logic [3:0]  drive_q, drive_d;

    // Combinational helpers
    logic        instr_tick;
    logic        timer_tick;
    logic [1:0]  ext_bits;
    logic        timer_on;
    logic        period_match;
    logic        duty_match;
    logic        pwm_mode;
    logic        accept;
    logic        wr_en;
    logic [7:0]  wdat;
    logic [7:0]  rd_val;
    logic [9:0]  duty_next;
    logic        half_a;
    logic        half_b;
    logic        mod;
    logic [3:0]  act;

    // ============================================================
    // Instruction-cycle phase and prescaler
    assign instr_tick = (phase_q == PHASE_LAST);
    assign timer_on   = timer_ctrl_q[TC_ON_BIT];

    pwm_prescaler u_prescaler (
        .clk             (clk),
        .rst_n           (rst_n),
        .instr_tick      (instr_tick),
        .run             (timer_on),
        .prescale_select (timer_ctrl_q[1:0]),
        .phase           (phase_q),
        .timer_tick      (timer_tick),
        .ext_bits        (ext_bits)
    );

    // ============================================================
    // AHB-Lite slave: writes zero-wait, reads one wait state
    // The wait lets a read that follows a write see the new value.
    assign accept = hsel & hready & htrans[1];
    assign wr_en  = wr_pend_q & hit_q;
    assign wdat   = hwdata[7:0];

    always_comb begin
        idx_d     = idx_q;
        hit_d     = hit_q;
        wr_pend_d = 1'b0;
        rd_wait_d = 1'b0;
        if (accept) begin
            idx_d     = haddr[9:2];
            hit_d     = (haddr[31:ADDR_HI_LSB] == '0) && (haddr[1:0] == 2'h0);
            wr_pend_d = hwrite;
            rd_wait_d = ~hwrite;
        end
    end

    always_comb begin
        rd_val = 8'h00;
        case (idx_q)
            IDX_IRQ_FLAGS:    rd_val = irq_flags_q;
            IDX_TIMER_COUNT:  rd_val = timer_count_q;
            IDX_TIMER_CTRL:   rd_val = timer_ctrl_q;
            IDX_DUTY_WRITE:   rd_val = duty_write_q;
            IDX_DUTY_BUF:     rd_val = duty_buf_q;
            IDX_MODULE_CTRL:  rd_val = module_ctrl_q;
            IDX_IRQ_EN:       rd_val = irq_en_q;
            IDX_PERIOD_LIMIT: rd_val = period_limit_q;
            IDX_DEADBAND:     rd_val = deadband_q;
            default:          rd_val = 8'h00;
        endcase
        hrdata_d = hrdata_q;
        if (rd_wait_q) begin
            hrdata_d = hit_q ? {24'h000000, rd_val} : 32'h00000000;
        end
    end

    assign hreadyout = ~rd_wait_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    // ============================================================
    // Period timer, duty buffering and postscaled flag
    // Modes 11xx select PWM
    assign pwm_mode     = (module_ctrl_q[3:2] == MODE_PWM_HI);
    assign period_match = timer_tick & (timer_count_q == period_limit_q);
    // Ten-bit duty from byte and bits 5:4
    assign duty_next    = {duty_write_q, module_ctrl_q[MC_DUTY_LSB+1:MC_DUTY_LSB]};
    // Never equal when duty exceeds period
    assign duty_match   = ({duty_buf_q, duty_lat_q} == {timer_count_q, ext_bits});

    always_comb begin
        irq_flags_d    = irq_flags_q;
        timer_count_d  = timer_count_q;
        timer_ctrl_d   = timer_ctrl_q;
        duty_write_d   = duty_write_q;
        duty_buf_d     = duty_buf_q;
        duty_lat_d     = duty_lat_q;
        module_ctrl_d  = module_ctrl_q;
        irq_en_d       = irq_en_q;
        period_limit_d = period_limit_q;
        deadband_d     = deadband_q;
        post_cnt_d     = post_cnt_q;
        // Writes land in the bus registers; duty_buf_q is never written from the bus
        if (wr_en) begin
            case (idx_q)
                IDX_IRQ_FLAGS:    irq_flags_d    = wdat & IRQ_MASK;
                IDX_TIMER_COUNT:  timer_count_d  = wdat;
                IDX_TIMER_CTRL:   timer_ctrl_d   = wdat & TC_MASK;
                IDX_DUTY_WRITE:   duty_write_d   = wdat;
                IDX_MODULE_CTRL:  module_ctrl_d  = wdat;
                IDX_IRQ_EN:       irq_en_d       = wdat & IRQ_MASK;
                IDX_PERIOD_LIMIT: period_limit_d = wdat;
                IDX_DEADBAND:     deadband_d     = wdat;
                default:          irq_en_d       = irq_en_q;
            endcase
        end
        // Advance on prescaled tick while on
        if (!(wr_en && idx_q == IDX_TIMER_COUNT) && timer_tick) begin
            // Match clears on the next increment
            timer_count_d = period_match ? 8'h00 : timer_count_q + 8'h01;
        end
        if (period_match && pwm_mode) begin
            duty_buf_d = duty_next[9:2];
            duty_lat_d = duty_next[1:0];
        end
        if (period_match) begin
            if (post_cnt_q == timer_ctrl_q[TC_POST_LSB+3:TC_POST_LSB]) begin
                post_cnt_d                  = 4'h0;
                irq_flags_d[FLAG_TIMER_BIT] = 1'b1;
            end else begin
                post_cnt_d = post_cnt_q + 4'h1;
            end
        end
    end

    // ============================================================
    // Standard waveform
    always_comb begin
        phase_d = phase_q + 2'h1;
        start_d = period_match;
        std_d   = std_q;
        lag_d   = {lag_q[ENH_LAG-2:0], std_q};
        if (!pwm_mode) begin
            std_d = 1'b0;
        // Set at period start unless zero duty
        // Only prescaler and limit shape the period
        end else if (start_q) begin
            std_d = ({duty_buf_q, duty_lat_q} != 10'h000);
        end else if (duty_match) begin
            std_d = 1'b0;
        end
    end

    // ============================================================
    // Enhanced stage: buffered controls, lag, dead band, polarity
    always_comb begin
        cfg_d    = cfg_q;
        enh_on_d = enh_on_q;
        db_d     = db_q;
        if (period_match) begin
            cfg_d    = {module_ctrl_q[MC_CFG_LSB+1:MC_CFG_LSB],
                        module_ctrl_q[MC_POL_AC_BIT], module_ctrl_q[MC_POL_BD_BIT]};
            enh_on_d = pwm_mode;
        end
        if (!pwm_mode) begin
            enh_on_d = 1'b0;
        end
        // Dead band at duty or period boundary
        if (period_match || (std_q && duty_match)) begin
            db_d = deadband_q[6:0];
        end
    end

    assign mod    = lag_q[ENH_LAG-1];

    pwm_deadband u_db_a (
        .clk        (clk),
        .rst_n      (rst_n),
        .mod_in     (mod & enh_on_q),
        .delay      (db_q),
        .mod_out    (half_a)
    );

    pwm_deadband u_db_b (
        .clk        (clk),
        .rst_n      (rst_n),
        .mod_in     (~mod & enh_on_q),
        .delay      (db_q),
        .mod_out    (half_b)
    );

    always_comb begin
        act     = 4'h0;
        drive_d = 4'h0;
        case (cfg_q[3:2])
            CFG_SINGLE: begin
                act     = {3'h0, std_q};
                drive_d = 4'h1;
            end
            CFG_FWD: begin
                act     = {mod, 2'h0, 1'b1};
                drive_d = 4'hF;
            end
            CFG_HALF: begin
                act     = {2'h0, half_b, half_a};
                drive_d = 4'h3;
            end
            CFG_REV: begin
                act     = {1'b0, 1'b1, mod, 1'b0};
                drive_d = 4'hF;
            end
            default: act = 4'h0;
        endcase
        // Module off keeps every output low
        if (!pwm_mode || !enh_on_q) begin
            pins_d  = 4'h0;
            drive_d = pwm_mode ? 4'h1 : 4'h0;
        end else begin
            // Polarity per A/C and B/D pair
            pins_d = act ^ {cfg_q[0], cfg_q[1], cfg_q[0], cfg_q[1]};
        end
        // Until the enhanced stage turns on, the main pin follows the standard waveform
        if (pwm_mode && !enh_on_q) begin
            pins_d = {3'h0, std_q ^ module_ctrl_q[MC_POL_AC_BIT]};
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_flags_q    <= RST_ZERO;
            timer_count_q  <= RST_ZERO;
            timer_ctrl_q   <= RST_ZERO;
            duty_write_q   <= RST_ZERO;
            duty_buf_q     <= RST_ZERO;
            duty_lat_q     <= 2'h0;
            module_ctrl_q  <= RST_ZERO;
            irq_en_q       <= RST_ZERO;
            period_limit_q <= RST_PERIOD_LIMIT;
            deadband_q     <= RST_ZERO;
            post_cnt_q     <= 4'h0;
            wr_pend_q      <= 1'b0;
            rd_wait_q      <= 1'b0;
            idx_q          <= 8'h00;
            hit_q          <= 1'b0;
            hrdata_q       <= 32'h00000000;
            phase_q        <= 2'h0;
            start_q        <= 1'b0;
            std_q          <= 1'b0;
            lag_q          <= '0;
            cfg_q          <= 4'h0;
            enh_on_q       <= 1'b0;
            db_q           <= 7'h00;
            pins_q         <= 4'h0;
            drive_q        <= 4'h0;
        end else begin
            irq_flags_q    <= irq_flags_d;
            timer_count_q  <= timer_count_d;
            timer_ctrl_q   <= timer_ctrl_d;
            duty_write_q   <= duty_write_d;
            duty_buf_q     <= duty_buf_d;
            duty_lat_q     <= duty_lat_d;
            module_ctrl_q  <= module_ctrl_d;
            irq_en_q       <= irq_en_d;
            period_limit_q <= period_limit_d;
            deadband_q     <= deadband_d;
            post_cnt_q     <= post_cnt_d;
            wr_pend_q      <= wr_pend_d;
            rd_wait_q      <= rd_wait_d;
            idx_q          <= idx_d;
            hit_q          <= hit_d;
            hrdata_q       <= hrdata_d;
            phase_q        <= phase_d;
            start_q        <= start_d;
            std_q          <= std_d;
            lag_q          <= lag_d;
            cfg_q          <= cfg_d;
            enh_on_q       <= enh_on_d;
            db_q           <= db_d;
            pins_q         <= pins_d;
            drive_q        <= drive_d;
        end
    end

    // ============================================================
    // Pins
    assign main_pwm_pin = pins_q[0];
    assign bridge_out_b = pins_q[1];
    assign bridge_out_c = pins_q[2];
    assign bridge_out_d = pins_q[3];
    assign pin_drive    = drive_q;

endmodule : pwm_generator
`default_nettype wire

// File: logic/pwm_pkg.sv
// Constants shared by the enhanced PWM generator and its helpers.
// Assumes a 100 MHz core clock; one instruction cycle is four clocks.
package pwm_pkg;

    // ============================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0] IDX_IRQ_FLAGS    = 8'h0C;
    localparam logic [7:0] IDX_TIMER_COUNT  = 8'h11;
    localparam logic [7:0] IDX_TIMER_CTRL   = 8'h12;
    localparam logic [7:0] IDX_DUTY_WRITE   = 8'h15;
    localparam logic [7:0] IDX_DUTY_BUF     = 8'h16;
    localparam logic [7:0] IDX_MODULE_CTRL  = 8'h17;
    localparam logic [7:0] IDX_IRQ_EN       = 8'h8C;
    localparam logic [7:0] IDX_PERIOD_LIMIT = 8'h92;
    localparam logic [7:0] IDX_DEADBAND     = 8'h1C;
    localparam int         ADDR_HI_LSB      = 10;

    // ============================================================
    // Field positions and masks
    localparam int         TC_POST_LSB    = 3;
    localparam int         TC_ON_BIT      = 2;
    localparam int         MC_CFG_LSB     = 6;
    localparam int         MC_DUTY_LSB    = 4;
    localparam int         MC_POL_AC_BIT  = 1;
    localparam int         MC_POL_BD_BIT  = 0;
    localparam int         FLAG_TIMER_BIT = 1;
    localparam logic [7:0] IRQ_MASK       = 8'h47;
    localparam logic [7:0] TC_MASK        = 8'h7F;

    // ============================================================
    // Reset values
    localparam logic [7:0] RST_ZERO         = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;

    // ============================================================
    // Encodings
    localparam logic [1:0] CFG_SINGLE   = 2'h0;
    localparam logic [1:0] CFG_FWD      = 2'h1;
    localparam logic [1:0] CFG_HALF     = 2'h2;
    localparam logic [1:0] CFG_REV      = 2'h3;
    localparam logic [1:0] MODE_PWM_HI  = 2'h3;
    localparam logic [1:0] PRE_DIV1     = 2'h0;
    localparam logic [1:0] PRE_DIV4     = 2'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ============================================================
    // Timing
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         INSTR_NS        = 40;
    localparam int         CLKS_PER_INSTR  = INSTR_NS / CLK_PERIOD_NS;
    localparam logic [1:0] PHASE_LAST      = 2'(CLKS_PER_INSTR - 1);
    localparam int         ENH_LAG         = CLKS_PER_INSTR;

endpackage : pwm_pkg

// File: logic/pwm_prescaler.sv
// Period-timer prescaler: divides instruction ticks by 1, 4 or 16.
// Also supplies the two bits that extend the timer for duty compare.
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler
    import pwm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       instr_tick,
    input  wire logic       run,
    input  wire logic [1:0] prescale_select,
    input  wire logic [1:0] phase,
    output logic            timer_tick,
    output logic [1:0]      ext_bits
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       wrap;

    // ============================================================
    // Division ratio
    always_comb begin
        if (prescale_select == PRE_DIV1) begin
            wrap     = 1'b1;
            ext_bits = phase;
        end else if (prescale_select == PRE_DIV4) begin
            wrap     = (cnt_q[1:0] == 2'h3);
            ext_bits = cnt_q[1:0];
        end else begin
            wrap     = (cnt_q == 4'hF);
            ext_bits = cnt_q[3:2];
        end
        timer_tick = run & instr_tick & wrap;
        cnt_d      = cnt_q;
        if (!run) begin
            cnt_d = 4'h0;
        end else if (instr_tick) begin
            cnt_d = wrap ? 4'h0 : cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : pwm_prescaler
`default_nettype wire
